// >>> rtl/i2c_cfg_pkg.sv
// Shared constants and types for the two-wire configuration port and its host.
package i2c_cfg_pkg;

   // Address byte: fixed device-type nibble for parts carrying an EEPROM.
   localparam logic [3:0] DEV_TYPE    = 4'hA;
   localparam logic [3:0] BYTE_BITS   = 4'h8;

   // Pointer windows of the register bank and the configuration EEPROM.
   localparam logic [7:0] REG_FIRST   = 8'h00;
   localparam logic [7:0] REG_LAST    = 8'h13;
   localparam logic [7:0] EE_FIRST    = 8'h20;
   localparam logic [7:0] EE_LAST     = 8'h33;
   localparam int         BANK_DEPTH  = 20;

   // First-data-byte command codes.
   localparam logic [7:0] CMD_BLK_WR  = 8'h83;
   localparam logic [7:0] CMD_BLK_ALT = 8'hC0;
   localparam logic [7:0] CMD_BLK_RD  = 8'hC1;
   localparam logic [7:0] CMD_REBOOT  = 8'hC4;

   // Block length limits and the count returned by a block read.
   localparam logic [7:0] BLK_MIN     = 8'h01;
   localparam logic [7:0] BLK_MAX     = 8'h10;

   // Lock bit location inside the register bank.
   localparam logic [7:0] LOCK_REG    = 8'h13;
   localparam int         LOCK_BIT    = 0;

   // Host register map, byte addresses on the APB side.
   localparam logic [7:0] HOST_CMD_OFS  = 8'h00;
   localparam logic [7:0] HOST_STAT_OFS = 8'h04;
   // Command register fields.
   localparam int         CMD_OP_LSB  = 0;
   localparam int         CMD_DAT_LSB = 8;
   localparam int         CMD_NAK_BIT = 16;
   // Status register fields.
   localparam int         STAT_BUSY   = 0;
   localparam int         STAT_NAK    = 1;
   localparam int         STAT_DAT_LSB = 8;

   // Host bus operations.
   localparam logic [2:0] OP_START    = 3'h1;
   localparam logic [2:0] OP_STOP     = 3'h2;
   localparam logic [2:0] OP_WRITE    = 3'h3;
   localparam logic [2:0] OP_READ     = 3'h4;

   // Serial clock timing made by the host from its own clock.
   localparam int         CLK_PERIOD_NS = 25;
   localparam int         SCL_PERIOD_NS = 5000;
   localparam int         QUARTER_CYC   =
      SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   localparam logic [7:0] QUARTER_LAST  = 8'(QUARTER_CYC - 1);

   // Device byte engine, Gray coded along receive, acknowledge, send.
   typedef enum logic [2:0] {
      D_IDLE = 3'h0,
      D_RECV = 3'h1,
      D_ACK  = 3'h3,
      D_SEND = 3'h2,
      D_RACK = 3'h6
   } dev_state_t;

   // Position of the next received byte inside a transaction.
   typedef enum logic [2:0] {
      PH_ADDR  = 3'h0,
      PH_FIRST = 3'h1,
      PH_DATA  = 3'h3,
      PH_COUNT = 3'h2,
      PH_BLK   = 3'h6,
      PH_HOLD  = 3'h7
   } phase_t;

   // Host bus sequencer.
   typedef enum logic [1:0] {
      M_IDLE  = 2'h0,
      M_START = 2'h1,
      M_BIT   = 2'h3,
      M_STOP  = 2'h2
   } host_state_t;

endpackage : i2c_cfg_pkg

// >>> rtl/i2c_config_slave.sv
// Configuration port end: two-wire slave over the register bank and EEPROM.
//
// Design decision made here: the pointer is kept across a stop.
`timescale 1ns/10ps
`default_nettype none
module i2c_config_slave (
   // Clock and reset.
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   // Serial link.
   i2c_link_if.device                link,
   // Address straps, pins from the board.
   input  wire logic                 addrStrapLow,
   input  wire logic                 addrStrapHigh,
   // Busy indications from the reboot loader and EEPROM programmer.
   input  wire logic                 rebootBusy,
   input  wire logic                 eeBusy,
   // Software reboot request, one-cycle pulse.
   output logic                      rebootReq,
   // EEPROM write strobe with address and data.
   output logic                      eeWrStb,
   output logic [7:0]                eeWrAddr,
   output logic [7:0]                eeWrData,
   // EEPROM read port, data returned in the same cycle.
   output logic [7:0]                eeRdAddr,
   input  wire logic [7:0]           eeRdData,
   // Register bank contents and the lock flag for the sequencer.
   output logic [8*i2c_cfg_pkg::BANK_DEPTH-1:0] cfgBank,
   output logic                      cfgLock
);

   // Entire state of the port.
   typedef struct packed {
      logic [1:0]              sclSync;   // Serial clock synchroniser.
      logic [1:0]              sdaSync;   // Serial data synchroniser.
      logic [1:0][1:0]         strapSync; // Strap synchroniser.
      logic                    sclPrev;   // Clock level one cycle back.
      logic                    sdaPrev;   // Data level one cycle back.
      i2c_cfg_pkg::dev_state_t st;        // Byte engine state.
      i2c_cfg_pkg::phase_t     ph;        // Byte position in transaction.
      logic [3:0]              bitCnt;    // Bits shifted in this byte.
      logic [7:0]              shift;     // Receive and transmit shifter.
      logic                    ackDrive;  // Pull low in the ninth clock.
      logic                    rdMode;    // Current address is a read.
      logic                    armed;     // Block read command seen.
      logic [7:0]              ptr;       // Internal address pointer.
      logic [7:0]              wAddr;     // Write byte/word target.
      logic                    reboot;    // Reboot request pulse.
      logic                    eeStb;     // EEPROM write pulse.
      logic [7:0]              eeAddr;    // EEPROM write address.
      logic [7:0]              eeData;    // EEPROM write data.
      logic [i2c_cfg_pkg::BANK_DEPTH-1:0][7:0] bank; // Register bank.
   } dev_t;

   dev_t q;
   dev_t d;

   // True when the pointer lies in the register bank window.
   function automatic logic isReg(input logic [7:0] a);
      isReg = (a >= i2c_cfg_pkg::REG_FIRST) && (a <= i2c_cfg_pkg::REG_LAST);
   endfunction : isReg

   // True when the pointer lies in the EEPROM window.
   function automatic logic isEe(input logic [7:0] a);
      isEe = (a >= i2c_cfg_pkg::EE_FIRST) && (a <= i2c_cfg_pkg::EE_LAST);
   endfunction : isEe

   // Pointer advance that sticks at the top of either window.
   function automatic logic [7:0] satInc(input logic [7:0] a);
      if ((a == i2c_cfg_pkg::REG_LAST) || (a == i2c_cfg_pkg::EE_LAST)) begin
         satInc = a;
      end else begin
         satInc = a + 8'h01;
      end
   endfunction : satInc

   // Bus edges and conditions seen on the synchronised lines.
   logic sclRise;
   logic sclFall;
   logic startSeen;
   logic stopSeen;
   logic lockOn;
   logic busy;
   logic ack;
   logic wrReq;
   logic [7:0] wrAt;
   logic [7:0] rdByte;

   assign sclRise   = q.sclSync[1] & ~q.sclPrev;
   assign sclFall   = ~q.sclSync[1] & q.sclPrev;
   assign startSeen = q.sclSync[1] & q.sclPrev & q.sdaPrev & ~q.sdaSync[1];
   assign stopSeen  = q.sclSync[1] & q.sclPrev & ~q.sdaPrev & q.sdaSync[1];
   assign lockOn    = q.bank[i2c_cfg_pkg::LOCK_REG[4:0]][i2c_cfg_pkg::LOCK_BIT];
   assign busy      = rebootBusy | eeBusy;

   // Byte at the pointer: bank reads are local, EEPROM reads go outside.
   assign eeRdAddr  = q.ptr;
   assign rdByte    = isReg(q.ptr) ? q.bank[q.ptr[4:0]] : eeRdData;

   // Next-state logic for the whole port.
   always_comb begin
      d        = q;
      ack      = 1'b0;
      wrReq    = 1'b0;
      wrAt     = q.wAddr;
      d.sclSync   = {q.sclSync[0], link.scl};
      d.sdaSync   = {q.sdaSync[0], link.sda};
      d.strapSync = {q.strapSync[0], {addrStrapHigh, addrStrapLow}};
      d.sclPrev   = q.sclSync[1];
      d.sdaPrev   = q.sdaSync[1];
      d.reboot    = 1'b0;
      d.eeStb     = 1'b0;
      if (startSeen) begin
         // A start or repeated start always opens a fresh address byte.
         d.st       = i2c_cfg_pkg::D_RECV;
         d.ph       = i2c_cfg_pkg::PH_ADDR;
         d.bitCnt   = 4'h0;
         d.ackDrive = 1'b0;
      end else if (stopSeen) begin
         // The pointer is deliberately left alone here.
         d.st       = i2c_cfg_pkg::D_IDLE;
         d.armed    = 1'b0;
         d.ackDrive = 1'b0;
      end else begin
         case (q.st)
            i2c_cfg_pkg::D_RECV: begin
               if (sclRise) begin
                  d.shift  = {q.shift[6:0], q.sdaSync[1]};
                  d.bitCnt = q.bitCnt + 4'h1;
               end
               if (sclFall && (q.bitCnt == i2c_cfg_pkg::BYTE_BITS)) begin
                  case (q.ph)
                     i2c_cfg_pkg::PH_ADDR: begin
                        // Type nibble and straps must match; bit 1 is free.
                        if ((q.shift[7:4] == i2c_cfg_pkg::DEV_TYPE) &&
                            (q.shift[3:2] == q.strapSync[1]) && !busy) begin
                           ack      = 1'b1;
                           d.rdMode = q.shift[0];
                           d.ph     = i2c_cfg_pkg::PH_FIRST;
                        end
                     end
                     i2c_cfg_pkg::PH_FIRST: begin
                        if (q.shift == i2c_cfg_pkg::CMD_BLK_RD) begin
                           ack     = !busy;
                           d.armed = !busy;
                           d.ph    = i2c_cfg_pkg::PH_HOLD;
                        end else if (q.shift == i2c_cfg_pkg::CMD_BLK_ALT) begin
                           ack  = 1'b1;
                           d.ph = i2c_cfg_pkg::PH_HOLD;
                        end else if (q.shift == i2c_cfg_pkg::CMD_BLK_WR) begin
                           ack  = 1'b1;
                           d.ph = i2c_cfg_pkg::PH_COUNT;
                        end else if (q.shift == i2c_cfg_pkg::CMD_REBOOT) begin
                           ack      = 1'b1;
                           d.reboot = 1'b1;
                           d.ph     = i2c_cfg_pkg::PH_HOLD;
                        end else if (isReg(q.shift) || isEe(q.shift)) begin
                           ack     = 1'b1;
                           d.ptr   = q.shift;
                           d.wAddr = q.shift;
                           d.ph    = i2c_cfg_pkg::PH_DATA;
                        end
                        // Anything else goes unanswered and is dropped.
                     end
                     i2c_cfg_pkg::PH_DATA: begin
                        // Write byte, and the second byte of a word.
                        ack     = 1'b1;
                        wrReq   = 1'b1;
                        d.wAddr = satInc(q.wAddr);
                     end
                     i2c_cfg_pkg::PH_COUNT: begin
                        ack  = (q.shift >= i2c_cfg_pkg::BLK_MIN) &&
                               (q.shift <= i2c_cfg_pkg::BLK_MAX);
                        d.ph = i2c_cfg_pkg::PH_BLK;
                     end
                     i2c_cfg_pkg::PH_BLK: begin
                        // Relies on the host having set the pointer first.
                        ack   = 1'b1;
                        wrReq = 1'b1;
                        wrAt  = q.ptr;
                        d.ptr = satInc(q.ptr);
                     end
                     default: begin
                        ack = 1'b0;
                     end
                  endcase
                  // A refused byte leaves the line released in clock nine.
                  d.st       = ack ? i2c_cfg_pkg::D_ACK : i2c_cfg_pkg::D_IDLE;
                  d.ackDrive = ack;
               end
            end
            i2c_cfg_pkg::D_ACK: begin
               // Hold the acknowledge until the ninth clock falls.
               if (sclFall) begin
                  d.ackDrive = 1'b0;
                  d.bitCnt   = 4'h0;
                  if (q.rdMode) begin
                     d.st = i2c_cfg_pkg::D_SEND;
                     if (q.armed) begin
                        d.shift = i2c_cfg_pkg::BLK_MAX;
                        d.armed = 1'b0;
                     end else begin
                        d.shift = rdByte;
                        d.ptr   = satInc(q.ptr);
                     end
                  end else begin
                     d.st = i2c_cfg_pkg::D_RECV;
                  end
               end
            end
            i2c_cfg_pkg::D_SEND: begin
               // One bit per low phase, most significant first.
               if (sclFall) begin
                  if (q.bitCnt == (i2c_cfg_pkg::BYTE_BITS - 4'h1)) begin
                     d.st = i2c_cfg_pkg::D_RACK;
                  end else begin
                     d.shift  = {q.shift[6:0], 1'b0};
                     d.bitCnt = q.bitCnt + 4'h1;
                  end
               end
            end
            i2c_cfg_pkg::D_RACK: begin
               // Host acknowledge in clock nine decides whether to go on.
               if (sclRise && q.sdaSync[1]) begin
                  d.st = i2c_cfg_pkg::D_IDLE;
               end else if (sclFall) begin
                  d.st     = i2c_cfg_pkg::D_SEND;
                  d.bitCnt = 4'h0;
                  d.shift  = rdByte;
                  d.ptr    = satInc(q.ptr);
               end
            end
            default: begin
               d.st = i2c_cfg_pkg::D_IDLE;
            end
         endcase
      end
      // Stores; the lock bit itself always stays writable so it can clear.
      if (wrReq) begin
         if (isReg(wrAt)) begin
            if (!lockOn || (wrAt == i2c_cfg_pkg::LOCK_REG)) begin
               d.bank[wrAt[4:0]] = q.shift;
            end
         end else if (isEe(wrAt) && !lockOn) begin
            d.eeStb  = 1'b1;
            d.eeAddr = wrAt;
            d.eeData = q.shift;
         end
      end
   end

   // State register; idle lines reset high so no false start is seen.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q         <= '0;
         q.sclSync <= 2'b11;
         q.sdaSync <= 2'b11;
         q.sclPrev <= 1'b1;
         q.sdaPrev <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Open-drain data: only ever pulls low.
   assign link.sdaDevOut = 1'b0;
   assign link.sdaDevOe  = ((q.st == i2c_cfg_pkg::D_ACK) & q.ackDrive) |
                           ((q.st == i2c_cfg_pkg::D_SEND) & ~q.shift[7]);
   assign rebootReq = q.reboot;
   assign eeWrStb   = q.eeStb;
   assign eeWrAddr  = q.eeAddr;
   assign eeWrData  = q.eeData;
   assign cfgBank   = q.bank;
   assign cfgLock   = lockOn;

endmodule : i2c_config_slave
`default_nettype wire

// >>> rtl/i2c_host_master.sv
// Bus host end: APB-commanded two-wire master that makes the serial clock.
`timescale 1ns/10ps
`default_nettype none
module i2c_host_master (
   // Clock and reset.
   input  wire logic        clk_sys,
   input  wire logic        rst,
   // APB slave port.
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Serial link.
   i2c_link_if.host         link
);

   // Entire state of the host.
   typedef struct packed {
      logic [1:0]               sdaSync; // Data line synchroniser.
      i2c_cfg_pkg::host_state_t st;      // Sequencer state.
      logic [1:0]               qtr;     // Quarter of the bit period.
      logic [7:0]               tick;    // Quarter period down-counter.
      logic [3:0]               bitCnt;  // Bits done in this byte.
      logic [8:0]               tx;      // Eight bits plus clock nine.
      logic [8:0]               rx;      // Sampled line, nine bits.
      logic                     sclOut;  // Serial clock level.
      logic                     sdaRel;  // High releases the data line.
      logic [31:0]              rdData;  // APB read data.
      logic                     err;     // APB error answer.
   } host_t;

   host_t q;
   host_t d;
   logic  mapped;
   logic  cmdWr;
   logic  qDone;
   logic [2:0] op;

   assign mapped = (paddr == i2c_cfg_pkg::HOST_CMD_OFS) ||
                   (paddr == i2c_cfg_pkg::HOST_STAT_OFS);
   assign cmdWr  = psel & penable & pwrite &
                   (paddr == i2c_cfg_pkg::HOST_CMD_OFS);
   assign qDone  = (q.tick == 8'h00);
   assign op     = pwdata[i2c_cfg_pkg::CMD_OP_LSB +: 3];

   // Next-state logic: APB decode and the bus sequencer.
   always_comb begin
      d         = q;
      d.sdaSync = {q.sdaSync[0], link.sda};
      // Read data and error are caught in the setup cycle.
      if (psel && !penable) begin
         d.err    = !mapped;
         d.rdData = 32'h0000_0000;
         if (paddr == i2c_cfg_pkg::HOST_STAT_OFS) begin
            d.rdData[i2c_cfg_pkg::STAT_BUSY] = (q.st != i2c_cfg_pkg::M_IDLE);
            d.rdData[i2c_cfg_pkg::STAT_NAK]  = q.rx[0];
            d.rdData[i2c_cfg_pkg::STAT_DAT_LSB +: 8] = q.rx[8:1];
         end
      end
      if (q.st == i2c_cfg_pkg::M_IDLE) begin
         // A command while busy is dropped; software polls busy first.
         if (cmdWr) begin
            d.qtr    = 2'h0;
            d.tick   = i2c_cfg_pkg::QUARTER_LAST;
            d.bitCnt = 4'h0;
            case (op)
               i2c_cfg_pkg::OP_START: d.st = i2c_cfg_pkg::M_START;
               i2c_cfg_pkg::OP_STOP:  d.st = i2c_cfg_pkg::M_STOP;
               i2c_cfg_pkg::OP_WRITE: begin
                  d.st = i2c_cfg_pkg::M_BIT;
                  d.tx = {pwdata[i2c_cfg_pkg::CMD_DAT_LSB +: 8], 1'b1};
               end
               i2c_cfg_pkg::OP_READ: begin
                  // Release eight bits, then answer in clock nine.
                  d.st = i2c_cfg_pkg::M_BIT;
                  d.tx = {8'hFF, pwdata[i2c_cfg_pkg::CMD_NAK_BIT]};
               end
               default: d.st = i2c_cfg_pkg::M_IDLE;
            endcase
         end
      end else if (!qDone) begin
         d.tick = q.tick - 8'h01;
      end else begin
         d.tick = i2c_cfg_pkg::QUARTER_LAST;
         d.qtr  = q.qtr + 2'h1;
         case (q.st)
            i2c_cfg_pkg::M_START: begin
               // Release data, raise clock, pull data low, drop clock.
               case (q.qtr)
                  2'h0: d.sdaRel = 1'b1;
                  2'h1: d.sclOut = 1'b1;
                  2'h2: d.sdaRel = 1'b0;
                  default: begin
                     d.sclOut = 1'b0;
                     d.st     = i2c_cfg_pkg::M_IDLE;
                  end
               endcase
            end
            i2c_cfg_pkg::M_BIT: begin
               // Data changes only while the clock is low.
               case (q.qtr)
                  2'h0: d.sdaRel = q.tx[8];
                  2'h1: d.sclOut = 1'b1;
                  2'h2: d.rx     = {q.rx[7:0], q.sdaSync[1]};
                  default: begin
                     d.sclOut = 1'b0;
                     d.tx     = {q.tx[7:0], 1'b1};
                     d.bitCnt = q.bitCnt + 4'h1;
                     if (q.bitCnt == i2c_cfg_pkg::BYTE_BITS) begin
                        d.st = i2c_cfg_pkg::M_IDLE;
                     end
                  end
               endcase
            end
            i2c_cfg_pkg::M_STOP: begin
               // Pull data low, raise clock, then release data.
               case (q.qtr)
                  2'h0: d.sdaRel = 1'b0;
                  2'h1: d.sclOut = 1'b1;
                  2'h2: d.sdaRel = 1'b1;
                  default: d.st  = i2c_cfg_pkg::M_IDLE;
               endcase
            end
            default: d.st = i2c_cfg_pkg::M_IDLE;
         endcase
      end
   end

   // State register; the bus rests with both lines high.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         q         <= '0;
         q.sdaSync <= 2'b11;
         q.sclOut  <= 1'b1;
         q.sdaRel  <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // Zero-wait APB answers; data and error come from flip-flops.
   assign pready         = 1'b1;
   assign prdata         = q.rdData;
   assign pslverr        = q.err;
   assign link.sclOut    = q.sclOut;
   assign link.sdaMstOut = 1'b0;
   assign link.sdaMstOe  = ~q.sdaRel;

endmodule : i2c_host_master
`default_nettype wire

// >>> rtl/i2c_link_if.sv
// Two-wire link between the bus host and the configuration port.
`timescale 1ns/10ps
`default_nettype none
interface i2c_link_if;
   // Serial clock, driven by the host alone.
   logic sclOut;
   logic scl;
   // Open-drain data line: each end pulls low while its enable is high.
   logic sdaMstOut;
   logic sdaMstOe;
   logic sdaDevOut;
   logic sdaDevOe;
   logic sda;

   // Resolved wire levels, pulled up when nobody drives low.
   assign scl = sclOut;
   assign sda = ~((sdaMstOe & ~sdaMstOut) | (sdaDevOe & ~sdaDevOut));

   modport device (input scl, input sda, output sdaDevOut, output sdaDevOe);
   modport host (output sclOut, output sdaMstOut, output sdaMstOe,
                 input sda);
endinterface : i2c_link_if
`default_nettype wire

// >>> verification/i2c_link_sva.sv
// Checker of the two-wire link between host and configuration port.
`timescale 1ns/10ps
`default_nettype none
module i2c_link_sva (
   // Clock, reset and link lines.
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic scl,
   input wire logic sda,
   input wire logic sdaMstOe,
   input wire logic sdaDevOe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // The device may move SDA only while SCL is low.
   devEdge_a:
      assert property ($changed(sdaDevOe) |-> !scl) else $error("sda moved");
   ackLate_a:
      assert property ($rose(sdaDevOe) |-> !$past(scl, 2)) else $error("early");
   hostQuiet_a:
      assert property (sdaDevOe && scl |-> !sdaMstOe) else $error("clash");
   stopRelease_a:
      assert property ($rose(sda) && scl && $past(scl) |=> !sdaDevOe [*8])
      else $error("driven after stop");
   noStart_a:
      assert property ($fell(sda) && scl && $past(scl) |-> !sdaDevOe)
      else $error("device made a start");
   sclLow_a:
      assert property ($fell(scl) |=> !scl [*8]) else $error("short low");
   sclHigh_a:
      assert property ($rose(scl) |=> scl [*8]) else $error("short high");
   // Reset is checked with the disable switched off on purpose.
   resetIdle_a:
      assert property (disable iff (1'b0) rst |=> !sdaDevOe && scl)
      else $error("not idle in reset");
endmodule : i2c_link_sva
`default_nettype wire

// >>> verification/tb_i2c_config_slave.sv
// Self-checking bench: host and configuration port joined over the link.
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_config_slave;
   logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, rebootReq;
   logic eeBusy, rbBusy, eeWrStb, cfgLock;
   logic [1:0] straps;
   logic [7:0] paddr, eeWrAddr, eeWrData, eeRdAddr;
   logic [31:0] pwdata, prdata, st;
   logic [159:0] cfgBank;
   int errCount, nCompared, boots, strobes;
   i2c_link_if link();
   i2c_host_master i2c_host_master_i (.clk_sys(clk_sys), .rst(rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link.host));
   i2c_config_slave i2c_config_slave_i (.clk_sys(clk_sys), .rst(rst),
      .link(link.device), .addrStrapLow(straps[0]),
      .addrStrapHigh(straps[1]),
      .rebootBusy(rbBusy), .eeBusy(eeBusy), .rebootReq(rebootReq),
      .eeWrStb(eeWrStb), .eeWrAddr(eeWrAddr), .eeWrData(eeWrData),
      .eeRdAddr(eeRdAddr), .eeRdData(8'h00), .cfgBank(cfgBank),
      .cfgLock(cfgLock));
   i2c_link_sva i2c_link_sva_i (.clk_sys(clk_sys), .rst(rst),
      .scl(link.scl), .sda(link.sda), .sdaMstOe(link.sdaMstOe),
      .sdaDevOe(link.sdaDevOe));
   // Clock source.
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   // Reboot pulses are counted so a missing or doubled one shows.
   always @(posedge clk_sys) if (rebootReq === 1'b1) boots++;
   // EEPROM strobes are counted so a refused store shows as well.
   always @(posedge clk_sys) if (eeWrStb === 1'b1) strobes++;
   task automatic closeOut;
      if (errCount == 0 && nCompared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : closeOut
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      nCompared++;
      if (s !== e) begin
         errCount++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   // One APB transfer; held until pready is seen high.
   task automatic apb(input logic [7:0] a, input logic [31:0] d,
                      input logic w);
      psel <= 1'b1; paddr <= a; pwdata <= d; pwrite <= w;
      @(posedge clk_sys); penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      st = prdata; psel <= 1'b0; penable <= 1'b0;
      // One idle edge, so the next setup never re-drives psel at once.
      @(posedge clk_sys);
   endtask : apb
   // One bus operation, then status polled until the host is idle.
   task automatic op(input logic [2:0] o, input logic [7:0] b,
                     input logic nak);
      apb(8'h00, {15'h0000, nak, b, 5'h00, o}, 1'b1);
      @(posedge clk_sys);
      do apb(8'h04, 32'h0, 1'b0); while (st[0] !== 1'b0);
   endtask : op
   task automatic wr(input logic [7:0] b, input logic nak);
      op(3'h3, b, 1'b0);
      chk(st[1], nak);
   endtask : wr
   // Straps are 2'b10, so the port answers at A8h to ABh only.
   task automatic tSend;
      op(3'h1, 8'h00, 1'b0); wr(8'hAA, 1'b0); wr(8'h05, 1'b0);
      op(3'h2, 8'h00, 1'b0); chk(eeRdAddr, 8'h05);
      op(3'h1, 8'h00, 1'b0); wr(8'hA4, 1'b1); op(3'h2, 8'h00, 1'b0);
   endtask : tSend
   task automatic tWrite;
      op(3'h1, 8'h00, 1'b0); wr(8'hA8, 1'b0); wr(8'h02, 1'b0);
      wr(8'h5A, 1'b0); op(3'h1, 8'h00, 1'b0); wr(8'hA8, 1'b0);
      wr(8'h15, 1'b1); op(3'h2, 8'h00, 1'b0);
      chk(cfgBank[23:16], 8'h5A);
   endtask : tWrite
   // The last block byte sets the lock bit for the read scenario.
   task automatic tBlock;
      op(3'h1, 8'h00, 1'b0); wr(8'hA8, 1'b0); wr(8'h12, 1'b0);
      op(3'h1, 8'h00, 1'b0); wr(8'hA8, 1'b0); wr(8'h83, 1'b0);
      wr(8'h03, 1'b0); wr(8'h11, 1'b0); wr(8'h22, 1'b0); wr(8'h45, 1'b0);
      op(3'h2, 8'h00, 1'b0);
      chk(cfgBank[159:144], 16'h4511);
      chk(cfgLock, 1'b1);
   endtask : tBlock
   // A locked write to 02h is acknowledged but must not land.
   task automatic tRead;
      op(3'h1, 8'h00, 1'b0); wr(8'hA8, 1'b0); wr(8'h02, 1'b0);
      wr(8'h99, 1'b0); op(3'h1, 8'h00, 1'b0); wr(8'hA8, 1'b0);
      wr(8'hC1, 1'b0); op(3'h1, 8'h00, 1'b0);
      wr(8'hA9, 1'b0); op(3'h4, 8'h00, 1'b0);
      chk(st[15:8], 8'h10);
      op(3'h4, 8'h00, 1'b1); chk(st[15:8], 8'h5A);
      op(3'h2, 8'h00, 1'b0);
   endtask : tRead
   task automatic tMisc;
      op(3'h1, 8'h00, 1'b0); wr(8'hA8, 1'b0); wr(8'h25, 1'b0);
      wr(8'h77, 1'b0); op(3'h2, 8'h00, 1'b0);
      chk({eeWrAddr, eeWrData}, 16'h2577);
      chk(strobes, 1);
      op(3'h1, 8'h00, 1'b0); wr(8'hA8, 1'b0); rbBusy <= 1'b1;
      wr(8'hC1, 1'b1); rbBusy <= 1'b0;
      eeBusy <= 1'b1; op(3'h1, 8'h00, 1'b0); wr(8'hA8, 1'b1);
      op(3'h2, 8'h00, 1'b0); eeBusy <= 1'b0;
      op(3'h1, 8'h00, 1'b0); wr(8'hA8, 1'b0); wr(8'hC4, 1'b0);
      op(3'h2, 8'h00, 1'b0); chk(boots, 1);
   endtask : tMisc
   // Watchdog: the whole run needs roughly 62000 cycles.
   initial begin
      repeat (90000) @(posedge clk_sys);
      errCount++;
      closeOut();
   end
   initial begin
      {rst, psel, penable, pwrite, eeBusy, rbBusy} = 6'h20;
      straps = 2'b10;
      paddr = 8'h00; pwdata = 32'h0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      @(posedge clk_sys);
      tSend(); tWrite(); tMisc(); tBlock(); tRead();
      closeOut();
   end
endmodule : tb_i2c_config_slave
`default_nettype wire
